// ### design/field_store_pkg.sv
// constants and carriers for the register-indirect-with-offset field store
package field_store_pkg;

   // ---------------------------------------------------------------
   // opcode layout
   // ---------------------------------------------------------------
   localparam logic [5:0] OPC_STORE_IND_OFS = 6'h2c;
   localparam int         OPC_MSB           = 15;
   localparam int         OPC_LSB           = 10;
   localparam int         FSEL_BIT          = 9;
   localparam int         SRC_MSB           = 8;
   localparam int         SRC_LSB           = 5;
   localparam int         FILE_BIT          = 4;
   localparam int         DST_MSB           = 3;
   localparam int         DST_LSB           = 0;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int         WORD_W            = 16;
   localparam int         ADDR_W            = 32;
   localparam int         FIELD_MAX         = 32;
   localparam int         BIT_OFS_W         = 4;
   localparam logic [4:0] SIZE_CODE_MAX     = 5'h00;
   localparam logic [5:0] WIDTH_MAX         = 6'h20;
   localparam logic [ADDR_W-1:0] WORD_STEP  = 32'h0000_0010;

   typedef struct packed {
      logic       ext;
      logic [4:0] size;
   } field_cfg_t;

   typedef struct packed {
      logic       file;
      logic [3:0] idx;
   } reg_sel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
      logic [WORD_W-1:0] mask;
   } mem_write_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_EXT   = 4'h2,
      ST_ADDR  = 4'h4,
      ST_WRITE = 4'h8
   } store_state_t;

   // size code 0 stands for a full 32-bit field
   function automatic logic [5:0] field_width(input logic [4:0] code);
      field_width = (code == SIZE_CODE_MAX) ? WIDTH_MAX : {1'b0, code};
   endfunction

endpackage

// ### design/field_merge.sv
// places a right-justified field into one memory word with its write mask
`timescale 1ns/1ns
module field_merge (
   input  wire logic [3:0]  bit_off_i,
   input  wire logic [31:0] field_i,
   input  wire logic [5:0]  width_i,
   input  wire logic [1:0]  word_i,
   output logic      [15:0] data_o,
   output logic      [15:0] mask_o,
   output logic      [1:0]  last_word_o
);
   logic [31:0] width_mask;
   logic [63:0] data_wide;
   logic [63:0] mask_wide;
   logic [6:0]  span;

   always_comb begin
      width_mask  = (width_i[5]) ? 32'hffff_ffff : ((32'h0000_0001 << width_i[4:0]) - 32'h0000_0001);
      // 64 bits wide so every word index stays in range, even the unused fourth
      data_wide   = {32'h0000_0000, field_i & width_mask} << bit_off_i;
      mask_wide   = {32'h0000_0000, width_mask} << bit_off_i;
      data_o      = data_wide[{word_i, 4'h0} +: 16];
      mask_o      = mask_wide[{word_i, 4'h0} +: 16];
      span        = {3'h0, bit_off_i} + {1'b0, width_i} - 7'h01;
      last_word_o = span[5:4];
   end
endmodule // field_merge

// ### design/field_store_decoder.sv
// decode and execute of the field store to register plus displacement
`timescale 1ns/1ns
module field_store_decoder (
   input  wire logic                             clk_i,
   input  wire logic                             reset_i,
   // instruction stream
   input  wire logic                             instr_valid_i,
   input  wire logic [15:0]                      instr_i,
   output logic                                  instr_ready_o,
   output logic                                  not_mine_o,
   // preset field settings
   input  wire field_store_pkg::field_cfg_t      field_size_zero_i,
   input  wire field_store_pkg::field_cfg_t      field_size_one_i,
   // register file read ports
   output field_store_pkg::reg_sel_t             src_sel_o,
   output field_store_pkg::reg_sel_t             dst_sel_o,
   input  wire logic [31:0]                      src_reg_i,
   input  wire logic [31:0]                      dst_reg_i,
   // memory field write
   output logic                                  mem_valid_o,
   output field_store_pkg::mem_write_t           mem_o,
   input  wire logic                             mem_ready_i,
   // status
   output logic                                  busy_o,
   output logic                                  done_o,
   output logic                                  ext_o
);
   import field_store_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   store_state_t      state_reg,  state_next;
   reg_sel_t          src_reg,    src_next;
   reg_sel_t          dst_reg,    dst_next;
   logic              fsel_reg,   fsel_next;
   logic [15:0]       disp_reg,   disp_next;
   logic [ADDR_W-1:0] addr_reg,   addr_next;
   logic [31:0]       field_reg,  field_next;
   logic [5:0]        width_reg,  width_next;
   logic              ext_reg,    ext_next;
   logic [1:0]        idx_reg,    idx_next;
   logic [1:0]        last_reg,   last_next;
   mem_write_t        mem_reg,    mem_next;
   logic              done_reg,   done_next;

   // ---------------------------------------------------------------
   // combinational helpers
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0] target;
   logic [ADDR_W-1:0] word_base;
   field_cfg_t        cfg_sel;
   logic [3:0]        mg_off;
   logic [31:0]       mg_field;
   logic [5:0]        mg_width;
   logic [1:0]        mg_word;
   logic [15:0]       mg_data;
   logic [15:0]       mg_mask;
   logic [1:0]        mg_last;
   logic              is_store;

   // ---------------------------------------------------------------
   // decode and address
   // ---------------------------------------------------------------
   assign is_store = (instr_i[OPC_MSB:OPC_LSB] == OPC_STORE_IND_OFS);
   assign target   = dst_reg_i + {{16{disp_reg[15]}}, disp_reg};
   assign cfg_sel  = fsel_reg ? field_size_one_i : field_size_zero_i;

   // ---------------------------------------------------------------
   // field placement
   // ---------------------------------------------------------------
   field_merge u_merge (
      .bit_off_i   (mg_off),
      .field_i     (mg_field),
      .width_i     (mg_width),
      .word_i      (mg_word),
      .data_o      (mg_data),
      .mask_o      (mg_mask),
      .last_word_o (mg_last)
   );

   // merge inputs: first word straight from the register file, later
   // words from the captured copy so a register update cannot tear it
   always_comb begin
      if (state_reg == ST_ADDR) begin
         mg_off    = target[BIT_OFS_W-1:0];
         mg_field  = src_reg_i;
         mg_width  = field_width(cfg_sel.size);
         mg_word   = 2'h0;
         word_base = {target[ADDR_W-1:BIT_OFS_W], 4'h0};
      end else begin
         mg_off    = addr_reg[BIT_OFS_W-1:0];
         mg_field  = field_reg;
         mg_width  = width_reg;
         mg_word   = idx_reg + 2'h1;
         word_base = {addr_reg[ADDR_W-1:BIT_OFS_W], 4'h0} + ({30'h0, mg_word} << BIT_OFS_W);
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next    = state_reg;
      src_next      = src_reg;
      dst_next      = dst_reg;
      fsel_next     = fsel_reg;
      disp_next     = disp_reg;
      addr_next     = addr_reg;
      field_next    = field_reg;
      width_next    = width_reg;
      ext_next      = ext_reg;
      idx_next      = idx_reg;
      last_next     = last_reg;
      mem_next      = mem_reg;
      done_next     = 1'b0;
      instr_ready_o = 1'b0;
      not_mine_o    = 1'b0;
      unique case (state_reg)
         // internal state 1: opcode decode
         ST_IDLE: begin
            instr_ready_o = 1'b1;
            if (instr_valid_i) begin
               if (is_store) begin
                  fsel_next      = instr_i[FSEL_BIT];
                  src_next.file  = instr_i[FILE_BIT];
                  dst_next.file  = instr_i[FILE_BIT];
                  src_next.idx   = instr_i[SRC_MSB:SRC_LSB];
                  dst_next.idx   = instr_i[DST_MSB:DST_LSB];
                  state_next     = ST_EXT;
               end else begin
                  not_mine_o     = 1'b1;
               end
            end
         end
         // internal state 2: displacement word
         ST_EXT: begin
            instr_ready_o = 1'b1;
            if (instr_valid_i) begin
               disp_next  = instr_i;
               state_next = ST_ADDR;
            end
         end
         // internal state 3: address add, first word staged
         ST_ADDR: begin
            addr_next     = target;
            field_next    = src_reg_i;
            width_next    = mg_width;
            ext_next      = cfg_sel.ext;
            idx_next      = 2'h0;
            last_next     = mg_last;
            mem_next.addr = word_base;
            mem_next.data = mg_data;
            mem_next.mask = mg_mask;
            state_next    = ST_WRITE;
         end
         // a single memory state, stepping idx_reg once per touched word
         ST_WRITE: begin
            // a stalled word keeps mem_o frozen, so the memory may take it late
            if (mem_ready_i) begin
               if (idx_reg == last_reg) begin
                  // done one cycle late: it marks the last word as really taken
                  done_next  = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  idx_next      = mg_word;
                  mem_next.addr = word_base;
                  mem_next.data = mg_data;
                  mem_next.mask = mg_mask;
               end
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // register stage
   // ---------------------------------------------------------------
   // reset loads constants only; every group updates on each clock
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_IDLE;
         src_reg   <= '0;
         dst_reg   <= '0;
         fsel_reg  <= 1'b0;
         disp_reg  <= 16'h0000;
         addr_reg  <= 32'h0000_0000;
         field_reg <= 32'h0000_0000;
         width_reg <= 6'h00;
         ext_reg   <= 1'b0;
         idx_reg   <= 2'h0;
         last_reg  <= 2'h0;
         mem_reg   <= '0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         src_reg   <= src_next;
         dst_reg   <= dst_next;
         fsel_reg  <= fsel_next;
         disp_reg  <= disp_next;
         addr_reg  <= addr_next;
         field_reg <= field_next;
         width_reg <= width_next;
         ext_reg   <= ext_next;
         idx_reg   <= idx_next;
         last_reg  <= last_next;
         mem_reg   <= mem_next;
         done_reg  <= done_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // no register write port and no flag port: destination and status
   // cannot be disturbed by this store
   assign src_sel_o   = src_reg;
   assign dst_sel_o   = dst_reg;
   assign mem_valid_o = (state_reg == ST_WRITE);
   assign mem_o       = mem_reg;
   // busy decodes the state directly: no extra cycle before the stream stalls
   assign busy_o      = (state_reg != ST_IDLE);
   assign done_o      = done_reg;
   assign ext_o       = ext_reg;
endmodule // field_store_decoder

// ### sim/field_store_monitor.sv
// port-level checks for the field store decoder
`timescale 1ns/1ns
module field_store_monitor (
   input wire logic                        clk_i,
   input wire logic                        reset_i,
   input wire logic                        instr_valid_i,
   input wire logic [15:0]                 instr_i,
   input wire logic                        instr_ready_o,
   input wire logic                        not_mine_o,
   input wire field_store_pkg::reg_sel_t   src_sel_o,
   input wire field_store_pkg::reg_sel_t   dst_sel_o,
   input wire logic                        mem_valid_o,
   input wire field_store_pkg::mem_write_t mem_o,
   input wire logic                        mem_ready_i,
   input wire logic                        busy_o,
   input wire logic                        done_o
);
   import field_store_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic        take;
   logic [15:0] op_q;
   logic [31:0] addr_q;
   assign take = instr_valid_i && !busy_o && instr_i[15:10] == OPC_STORE_IND_OFS;
   always_ff @(posedge clk_i) begin
      op_q <= instr_i;
      addr_q <= mem_o.addr;
   end
   property p_reject;
      instr_valid_i && !busy_o && instr_i[15:10] != OPC_STORE_IND_OFS |-> not_mine_o ##1 !busy_o;
   endproperty
   a_reject: assert property (p_reject) else $error("foreign opcode not dropped");
   property p_accept;
      take |=> busy_o && instr_ready_o && !not_mine_o;
   endproperty
   a_accept: assert property (p_accept) else $error("no displacement fetch");
   property p_sel;
      take |=> src_sel_o == {op_q[4], op_q[8:5]} && dst_sel_o == {op_q[4], op_q[3:0]};
   endproperty
   a_sel: assert property (p_sel) else $error("register select wrong");
   property p_timing;
      take ##1 instr_valid_i |=> !instr_ready_o ##1 mem_valid_o;
   endproperty
   a_timing: assert property (p_timing) else $error("write phase late");
   property p_hold;
      mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_o);
   endproperty
   a_hold: assert property (p_hold) else $error("write dropped in stall");
   property p_align;
      mem_valid_o |-> mem_o.addr[3:0] == 4'h0;
   endproperty
   a_align: assert property (p_align) else $error("word address unaligned");
   property p_step;
      mem_valid_o && mem_ready_i ##1 mem_valid_o |-> mem_o.addr == addr_q + WORD_STEP;
   endproperty
   a_step: assert property (p_step) else $error("word step wrong");
   property p_done;
      mem_valid_o && mem_ready_i ##1 !mem_valid_o |-> done_o && !busy_o;
   endproperty
   a_done: assert property (p_done) else $error("done missing");
   property p_refuse;
      mem_valid_o |-> !instr_ready_o && busy_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("word taken while writing");
   c_take: cover property (take);
   c_foreign: cover property (not_mine_o);
   c_stall: cover property (mem_valid_o && !mem_ready_i);
   c_done: cover property (done_o);
endmodule // field_store_monitor

bind field_store_decoder field_store_monitor u_mon (.*);

// ### sim/field_mem_model.sv
// bit-addressed memory answering masked word writes, with optional stalls
`timescale 1ns/1ns
module field_mem_model (
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   input  wire logic                        stall_i,
   input  wire logic                        mem_valid_i,
   input  wire field_store_pkg::mem_write_t mem_i,
   output logic                             mem_ready_o
);
   import field_store_pkg::*;
   logic [15:0] m [int];
   // unwritten words show an address pattern so kept bits are visible
   function automatic logic [15:0] rd(input int k);
      rd = m.exists(k) ? m[k] : k[15:0] ^ 16'h5a3c;
   endfunction
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mem_ready_o <= 1'b0;
      end else begin
         if (mem_valid_i && mem_ready_o) begin
            m[int'(mem_i.addr >> 4)] = (rd(int'(mem_i.addr >> 4)) & ~mem_i.mask) | (mem_i.data & mem_i.mask);
         end
         mem_ready_o <= stall_i ? 1'($urandom) : 1'b1;
      end
   end
endmodule // field_mem_model

// ### sim/tb_field_store_reg_indirect_offset.sv
// self-checking bench for the field store decoder
`timescale 1ns/1ns
module tb_field_store_reg_indirect_offset;
   import field_store_pkg::*;
   logic        clk_i = 0, reset_i = 1, instr_valid_i = 0, stall = 0;
   logic [15:0] instr_i = 16'h0000;
   field_cfg_t  field_size_zero = '0, field_size_one = '0;
   logic [31:0] rf [32];
   reg_sel_t    src_sel, dst_sel;
   mem_write_t  mem;
   logic        mem_valid, mem_ready, ready, not_mine, busy, done, ext;
   logic [31:0] r;
   logic [15:0] e [int];
   logic [4:0]  dsz [4] = '{5'h10, 5'h00, 5'h01, 5'h1f};
   logic [15:0] ddisp [4] = '{16'h0000, 16'h0010, 16'h8000, 16'hffec};
   int          err_count = 0, total_checks = 0;
   field_store_decoder dut (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(ready), .not_mine_o(not_mine), .field_size_zero_i(field_size_zero),
      .field_size_one_i(field_size_one), .src_sel_o(src_sel), .dst_sel_o(dst_sel), .src_reg_i(rf[src_sel]),
      .dst_reg_i(rf[dst_sel]), .mem_valid_o(mem_valid), .mem_o(mem), .mem_ready_i(mem_ready),
      .busy_o(busy), .done_o(done), .ext_o(ext));
   field_mem_model u_mem (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall),
      .mem_valid_i(mem_valid), .mem_i(mem), .mem_ready_o(mem_ready));
   initial forever #10 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic run_op(input logic f, file, input logic [3:0] s, d, input logic [15:0] disp);
      logic [31:0] a, b;
      int w, n, c;
      field_cfg_t cf;
      cf = f ? field_size_one : field_size_zero;
      w = cf.size == 5'h00 ? 32 : int'(cf.size);
      a = rf[{file, d}] + {{16{disp[15]}}, disp};
      e.delete();
      for (int i = 0; i < w; i++) begin
         b = a + 32'(i);
         if (!e.exists(int'(b >> 4))) e[int'(b >> 4)] = u_mem.rd(int'(b >> 4));
         e[int'(b >> 4)][b[3:0]] = rf[{file, s}][i];
      end
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= {OPC_STORE_IND_OFS, f, s, file, d};
      @(posedge clk_i);
      instr_i <= disp;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      c = 1;
      n = (int'(a[3:0]) + w + 15) / 16;
      do begin
         @(negedge clk_i);
         c++;
      end while (done !== 1'b1 && c < 200);
      chk("done", done, 1'b1);
      if (!stall) chk("cycles", c, 3 + n);
      chk("ext", ext, cf.ext);
      foreach (e[k]) chk("word", u_mem.rd(k), e[k]);
   endtask
   task automatic foreign(input logic [15:0] op);
      if (op[15:10] == OPC_STORE_IND_OFS) op[15] = 1'b0;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= op;
      @(negedge clk_i);
      chk("not_mine", not_mine, 1'b1);
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("busy", busy, 1'b0);
   endtask
   initial begin
      #1_000_000;
      err_count++;
      complete_run;
   end
   initial begin
      void'($urandom(32'hec9a));
      foreach (rf[i]) rf[i] = $urandom;
      rf[5] = 32'h0001_5530;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int t = 0; t < 48; t++) begin
         @(posedge clk_i);
         field_size_zero <= t < 4 ? field_cfg_t'({t[1], dsz[t]}) : field_cfg_t'(6'($urandom));
         field_size_one <= t < 4 ? field_cfg_t'({t[0], dsz[t]}) : field_cfg_t'(6'($urandom));
         stall <= t < 4 ? t[0] & t[1] : 1'($urandom);
         @(negedge clk_i);
         r = $urandom;
         if (t < 4) run_op(t[0], 1'b0, 4'h1, 4'h5, ddisp[t]);
         else if (t % 8 == 7) foreign(r[31:16]);
         else run_op(r[0], r[1], r[5:2], r[9:6], r[31:16]);
      end
      complete_run;
   end
endmodule // tb_field_store_reg_indirect_offset
